//--- test/mdpa_partner.sv
// Purpose: Far-side model driving strobe and alignment pins
// Assumes: One request makes one single-cycle pin pulse
// Notes: Both pins rest low outside requests
`timescale 1ns/10ps
module mdpa_partner (
    input wire logic core_clk,
    input wire logic fire,
    input wire logic toAlign,
    output logic strobeIn,
    output logic alignPulse
);
    // Pins launched from the conversion clock
    always_ff @(posedge core_clk)
    begin
        strobeIn <= fire && !toAlign;
        alignPulse <= fire && toAlign;
    end
endmodule // mdpa_partner

//--- test/tb.sv
// Purpose: Self-checking bench for mdpa_align
// Assumes: Partner makes the strobe and alignment pins
// Notes: Rows hold {divider reset, pointer reset, ctrl}
`timescale 1ns/10ps
`include "mdpa_cfg.svh"
module tb
    import mdpa_pkg::*;
;
    logic core_clk = 0, rst_n = 0, fire = 0, toAlign = 0, alarmClear = 0, strobeIn, alignPulse, strobeEvent;
    logic [2:0] alarmIn = 3'h0;
    mdpa_ctrl_t ctrl = 8'h00;
    mdpa_stat_t stat;
    logic [3:0] div0;
    logic [2:0] ptr0;
    logic [9:0] rows [4] = '{10'h361, 10'h141, 10'h020, 10'h262};
    int error_cnt = 0, cmp_count = 0, cyc = 0, i, n;
    `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
    mdpa_align u_mdpa_align (.core_clk(core_clk), .rst_n(rst_n), .strobeIn(strobeIn), .alignPulse(alignPulse),
        .ctrl(ctrl), .alarmIn(alarmIn), .alarmClear(alarmClear), .stat(stat), .strobeEvent(strobeEvent));
    mdpa_partner u_mdpa_partner (.core_clk(core_clk), .fire(fire), .toAlign(toAlign), .strobeIn(strobeIn),
        .alignPulse(alignPulse));
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (++cyc == 2000)
        begin
            error_cnt++;
            print_verdict();
        end
    task automatic print_verdict;
        $display("Compared %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic pulse(input logic a);
        toAlign = a;
        fire = 1;
        @(negedge core_clk);
        fire = 0;
        for (n = 0; n < 60 && strobeEvent !== 1'b1; n++)
            @(negedge core_clk);
        `CHK(strobeEvent, 1'b1)
        div0 = stat.clkDiv;
        ptr0 = stat.readPtr;
        @(negedge core_clk);
    endtask
    initial
    begin
        repeat (4) @(negedge core_clk);
        `CHK(stat, 16'h0080)
        rst_n = 1;
        for (i = 0; i < 4; i++)
        begin
            ctrl = rows[i][7:0];
            pulse(0);
            `CHK(n, 2)
            `CHK(stat.clkDiv, rows[i][9] ? 4'h0 : div0 + 4'h1)
            `CHK(stat.readPtr, rows[i][8] ? 3'h4 : ptr0 + 3'h1)
        end
        alarmIn = 3'h4;
        @(negedge core_clk);
        alarmIn = 3'h0;
        @(negedge core_clk);
        `CHK({stat.alarmStatus, stat.alarmPin}, 4'h9)
        alarmClear = 1;
        @(negedge core_clk);
        alarmClear = 0;
        `CHK({stat.alarmStatus, stat.alarmPin}, 4'h0)
        ctrl = 8'h90;
        for (i = 0; i < 40 && strobeEvent !== 1'b1; i++)
            @(negedge core_clk);
        `CHK(stat.fbDiv, 5'h1F)
        pulse(1);
        `CHK(n, 34)
        rst_n = 0; // Mid-run reset
        @(negedge core_clk);
        `CHK(stat, 16'h0080)
        rst_n = 1;
        @(negedge core_clk);
        `CHK(stat.fbDiv, 5'h01)
        `CHK(strobeEvent, 1'b0)
        `CHK({stat.clkDiv, stat.readPtr}, 7'h0D)
        print_verdict();
    end
endmodule // tb

//--- verilog/mdpa_align.sv
// Purpose: Strobe-driven divider and FIFO pointer alignment
// Assumes: core_clk is the conversion clock; pins are asynchronous
// Notes: Alarm inputs are sticky until alarmClear
`timescale 1ns/10ps
`include "mdpa_cfg.svh"
module mdpa_align
    import mdpa_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic strobeIn,
    input wire logic alignPulse,
    input wire mdpa_ctrl_t ctrl,
    input wire logic [`MDPA_ALM_W-1:0] alarmIn,
    input wire logic alarmClear,
    output mdpa_stat_t stat,
    output logic strobeEvent
);
    logic strobeS1_ff, strobeS2_ff, strobeS3_ff;
    logic alignS1_ff, alignS2_ff, alignS3_ff;
    logic [`MDPA_DIV_W-1:0] clkDiv_ff, nxt_clkDiv;
    logic [`MDPA_PTR_W-1:0] readPtr_ff, nxt_readPtr;
    logic [`MDPA_FB_W-1:0] fbDiv_ff, nxt_fbDiv;
    logic [`MDPA_ALM_W-1:0] alarm_ff, nxt_alarm;
    logic extEdge, intStrobe, fbReset, divReset, ptrReset;
    logic nxt_strobeS1, nxt_strobeS2, nxt_strobeS3;
    logic nxt_alignS1, nxt_alignS2, nxt_alignS3;
    logic [`MDPA_FB_W:0] gapCnt_ff, nxt_gapCnt;

    // Next values of the synchroniser chains
    always_comb
    begin
        nxt_strobeS1 = strobeIn;
        nxt_strobeS2 = strobeS1_ff;
        nxt_strobeS3 = strobeS2_ff;
        nxt_alignS1 = alignPulse;
        nxt_alignS2 = alignS1_ff;
        nxt_alignS3 = alignS2_ff;
    end

    // Pin synchronisers and edge history
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobeS1_ff <= 1'b0;
            strobeS2_ff <= 1'b0;
            strobeS3_ff <= 1'b0;
            alignS1_ff <= 1'b0;
            alignS2_ff <= 1'b0;
            alignS3_ff <= 1'b0;
        end
        else
        begin
            strobeS1_ff <= nxt_strobeS1;
            strobeS2_ff <= nxt_strobeS2;
            strobeS3_ff <= nxt_strobeS3;
            alignS1_ff <= nxt_alignS1;
            alignS2_ff <= nxt_alignS2;
            alignS3_ff <= nxt_alignS3;
        end
    end

    always_comb
    begin
        extEdge = strobeS2_ff && !strobeS3_ff;
        fbReset = ctrl.pllMode && ctrl.ndivSyncEna && alignS2_ff && !alignS3_ff;
        intStrobe = (fbDiv_ff == `MDPA_FB_MAX);
        strobeEvent = ctrl.pllMode ? intStrobe : extEdge;
        divReset = strobeEvent && ctrl.clkdivSyncEna && ctrl.clkdivSyncSel;
        ptrReset = strobeEvent && (ctrl.fifoInSel == `MDPA_SEL_STROBE);
        nxt_fbDiv = fbReset ? '0 : fbDiv_ff + 1'b1;
        nxt_clkDiv = divReset ? '0 : clkDiv_ff + 1'b1;
        nxt_readPtr = ptrReset ? `MDPA_PTR_RST : readPtr_ff + 1'b1;
        nxt_alarm = (alarm_ff & ~{`MDPA_ALM_W{alarmClear}}) | alarmIn;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fbDiv_ff <= '0;
            clkDiv_ff <= '0;
            readPtr_ff <= `MDPA_PTR_RST;
            alarm_ff <= '0;
        end
        else
        begin
            fbDiv_ff <= nxt_fbDiv;
            clkDiv_ff <= nxt_clkDiv;
            readPtr_ff <= nxt_readPtr;
            alarm_ff <= nxt_alarm;
        end
    end

    always_comb
    begin
        stat.alarmStatus = alarm_ff;
        stat.alarmPin = |alarm_ff;
        stat.clkDiv = clkDiv_ff;
        stat.readPtr = readPtr_ff;
        stat.fbDiv = fbDiv_ff;
    end

    // Cycles since the last internal strobe or feedback divider reset, for the period check
    always_comb
    begin
        if (intStrobe || fbReset)
        begin
            nxt_gapCnt = '0;
        end
        else if (gapCnt_ff != 6'h3F)
        begin
            nxt_gapCnt = gapCnt_ff + 6'h01;
        end
        else
        begin
            nxt_gapCnt = gapCnt_ff;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gapCnt_ff <= '0;
        end
        else
        begin
            gapCnt_ff <= nxt_gapCnt;
        end
    end

    // Pin rising through the synchroniser
    sequence strobe_rise_seq;
        !strobeS2_ff ##1 strobeS2_ff;
    endsequence

    sequence align_rise_seq;
        !alignS2_ff ##1 alignS2_ff;
    endsequence

    // Counters restart and then step on
    sequence div_restart_seq;
        (clkDiv_ff == '0) ##1 (clkDiv_ff == 4'h1);
    endsequence

    sequence ptr_restart_seq;
        (readPtr_ff == `MDPA_PTR_RST) ##1 (readPtr_ff == 3'h5);
    endsequence

    strobe_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!ctrl.pllMode && $rose(strobeS2_ff)) |-> strobeEvent)
        else $error("strobe edge missed");

    strobe_seq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        strobe_rise_seq |-> (ctrl.pllMode || strobeEvent))
        else $error("strobe rise gave no event");

    ext_once_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!ctrl.pllMode && strobeEvent) |=> (ctrl.pllMode || !strobeEvent))
        else $error("strobe event longer than one cycle");

    div_align_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (strobeEvent && ctrl.clkdivSyncEna && ctrl.clkdivSyncSel) |=> (clkDiv_ff == '0))
        else $error("divider not aligned");

    div_restart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (strobeEvent && ctrl.clkdivSyncEna && ctrl.clkdivSyncSel) |=> div_restart_seq)
        else $error("divider did not restart");

    div_free_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(strobeEvent && ctrl.clkdivSyncEna && ctrl.clkdivSyncSel) |=> (clkDiv_ff == $past(clkDiv_ff) + 4'h1))
        else $error("divider jumped without event");

    ptr_align_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (strobeEvent && ctrl.fifoInSel == `MDPA_SEL_STROBE) |=> (readPtr_ff == `MDPA_PTR_RST))
        else $error("pointer not aligned");

    ptr_restart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (strobeEvent && ctrl.fifoInSel == `MDPA_SEL_STROBE) |=> ptr_restart_seq)
        else $error("pointer did not restart");

    ptr_free_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(strobeEvent && ctrl.fifoInSel == `MDPA_SEL_STROBE) |=> (readPtr_ff == $past(readPtr_ff) + 3'h1))
        else $error("pointer jumped without event");

    fb_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fbReset |=> (fbDiv_ff == '0) ##31 intStrobe)
        else $error("feedback divider not reset");

    align_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (align_rise_seq ##0 (ctrl.pllMode && ctrl.ndivSyncEna)) |=> (fbDiv_ff == '0))
        else $error("alignment edge ignored");

    fb_refused_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!ctrl.ndivSyncEna && fbDiv_ff != 5'h1F) |=> (fbDiv_ff != '0))
        else $error("feedback divider reset while disabled");

    fb_free_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !fbReset |=> (fbDiv_ff == $past(fbDiv_ff) + 5'h01))
        else $error("feedback divider jumped");

    int_strobe_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ctrl.pllMode && intStrobe) |-> strobeEvent)
        else $error("internal strobe lost");

    pll_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ctrl.pllMode && !intStrobe) |-> !strobeEvent)
        else $error("strobe pin used in loop mode");

    int_period_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        intStrobe |-> (gapCnt_ff == 6'h1F))
        else $error("internal strobe period wrong");

    alarm_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (|alarmIn) |=> stat.alarmPin)
        else $error("alarm not reported");

    alarm_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (stat.alarmPin && !alarmClear && !(|alarmIn)) |=> stat.alarmPin)
        else $error("alarm dropped");

    alarm_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (alarmClear && (|alarmIn)) |=> ((stat.alarmStatus & $past(alarmIn)) == $past(alarmIn)))
        else $error("clear beat a new alarm");

    alarm_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (alarmClear && !(|alarmIn)) |=> !stat.alarmPin)
        else $error("alarm not cleared");

    no_sync_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!ctrl.clkdivSyncEna ##1 !ctrl.clkdivSyncEna) |-> (clkDiv_ff == $past(clkDiv_ff) + 1'b1))
        else $error("divider moved while sync disabled");
endmodule // mdpa_align

//--- verilog/mdpa_cfg.svh
// Purpose: Constants for the multi-device phase alignment block
// Assumes: Single 250 MHz core clock, no register bus
// Notes: Plain ports carry all control and status bits
// Summary of operation
// - Dual-source mode aligns timing to external strobe
// - FIFO absorbs skew; aligned devices read together
// - Strobe sampled in conversion clock domain
// - FIFO alarms shown in status and pin
// - PLL mode derives internal strobe from reference
// - Rising alignment edge resets feedback dividers
// - No fixed phase to frame or data clock
`ifndef MDPA_CFG_SVH
`define MDPA_CFG_SVH
`define MDPA_DIV_W 4
`define MDPA_DIV_MAX 4'hF
`define MDPA_PTR_W 3
`define MDPA_PTR_RST 3'h4
`define MDPA_FB_W 5
`define MDPA_FB_MAX 5'h1F
`define MDPA_SEL_W 4
`define MDPA_SEL_OFF 4'h0
`define MDPA_SEL_STROBE 4'h1
`define MDPA_ALM_W 3
`define MDPA_ALM_COLL 2
`endif

//--- verilog/mdpa_pkg.sv
// Purpose: Types for the multi-device phase alignment block
// Assumes: Constants come from mdpa_cfg.svh
// Notes: Control and status travel as packed structs
`include "mdpa_cfg.svh"
package mdpa_pkg;
    typedef struct packed {
        logic pllMode;
        logic clkdivSyncEna;
        logic clkdivSyncSel;
        logic ndivSyncEna;
        logic [`MDPA_SEL_W-1:0] fifoInSel;
    } mdpa_ctrl_t;
    typedef struct packed {
        logic [`MDPA_ALM_W-1:0] alarmStatus;
        logic alarmPin;
        logic [`MDPA_DIV_W-1:0] clkDiv;
        logic [`MDPA_PTR_W-1:0] readPtr;
        logic [`MDPA_FB_W-1:0] fbDiv;
    } mdpa_stat_t;
endpackage
